// *** src/ipf_defines.svh ***
/*
  Constants for the interrupt priority field bank: bus widths, register
  offsets, field positions, reset values and the priority encoding.
  Assumes it is included by its bare name by the package and the modules.
*/
`ifndef IPF_DEFINES_SVH
`define IPF_DEFINES_SVH

// ************************************************************
// Bus geometry
// ************************************************************
`define IPF_ADDR_W      12
`define IPF_DATA_W      32
`define IPF_STRB_W      4
`define IPF_LANE_W      8
`define IPF_REG_W       16

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define IPF_OFF_LOWV    12'h000
`define IPF_OFF_CHGT    12'h004
`define IPF_OFF_SER3    12'h008
`define IPF_OFF_STAT    12'h00C

// ************************************************************
// Priority fields
// ************************************************************
`define IPF_PRIO_W      3
`define IPF_NSRC        4
`define IPF_PRIO_RST    3'h4
`define IPF_PRIO_OFF    3'h0
`define IPF_PRIO_MAX    3'h7
`define IPF_LSB_LOWV    0
`define IPF_LSB_CHGT    4
`define IPF_LSB_S3RX    8
`define IPF_LSB_S3TX    12

// Source indices
`define IPF_SRC_LOWV    0
`define IPF_SRC_CHGT    1
`define IPF_SRC_S3RX    2
`define IPF_SRC_S3TX    3

`endif

// *** src/ipf_pkg.sv ***
/*
  Types for the interrupt priority field bank: bus state machine and the
  per-source configuration carriers.
  Assumes ipf_defines.svh is on the include path.
*/
`include "ipf_defines.svh"

package ipf_pkg;

  // ************************************************************
  // Bus handshake states, Gray along idle, setup, respond
  // ************************************************************
  typedef enum logic [1:0]
  {
    IPF_ST_IDLE  = 2'b00,
    IPF_ST_SETUP = 2'b01,
    IPF_ST_RESP  = 2'b11
  } ipf_apb_st_t;

  // ************************************************************
  // Per-source configuration
  // ************************************************************
  typedef struct packed
  {
    logic [`IPF_PRIO_W-1:0] prio;
    logic                   enabled;
  } ipf_src_cfg_t;

  typedef struct packed
  {
    ipf_src_cfg_t low_volt;
    ipf_src_cfg_t charge_time;
    ipf_src_cfg_t serial3_rx;
    ipf_src_cfg_t serial3_tx;
  } ipf_cfg_vec_t;

endpackage

// *** src/ipf_field.sv ***
/*
  One 3-bit interrupt priority field with its enable flag.
  Assumes a synchronous active-high reset and a one-cycle write strobe.
*/
`timescale 1ns/1ps

`include "ipf_defines.svh"

module ipf_field
  import ipf_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Write side
  input  wire logic                   wr_en,
  input  wire logic [`IPF_PRIO_W-1:0] wr_val,
  // Field state
  output logic      [`IPF_PRIO_W-1:0] prio_q,
  output logic                        enabled_q
);

  logic [`IPF_PRIO_W-1:0] prio_d;
  logic                   enabled_d;

  always_comb
  begin
    prio_d    = prio_q;
    enabled_d = enabled_q;
    if (srst)
    begin
      prio_d    = `IPF_PRIO_RST;              // [R7]
      enabled_d = 1'b1;
    end
    else if (wr_en)
    begin
      prio_d    = wr_val;                     // [R7]
      // Zero code parks the source; any other code is a live level
      enabled_d = (wr_val != `IPF_PRIO_OFF);  // [R2]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    prio_q    <= prio_d;
    enabled_q <= enabled_d;
  end

endmodule

// *** src/ipf_prio_regs.sv ***
/*
  Interrupt priority field bank behind an APB slave: low-voltage detect,
  charge-time unit and third serial port transmit and receive priorities.
  Assumes an APB master on sys_clk and request inputs synchronous to it.
*/
// The APB slave port and the register addresses are this design's own decisions.
// What this block does
// (R1) Low-voltage priority sits in bits 2..0; codes 1..7 are levels 1..7.
// (R2) A priority field holding zero disables its source; no request passes.
// (R3) Bits 15..3 of the low-voltage register ignore writes, read zero.
// (R4) Charge-time priority sits in bits 6..4, same encoding as low-voltage.
// (R5) Charge-time register bits 15..7 and 3..0 always read zero.
// (R6) Level seven is the highest priority any source may hold.
// (R7) Every field resets to level four and reads back the last write that strobed its byte lane.
`timescale 1ns/1ps

`include "ipf_defines.svh"

module ipf_prio_regs
  import ipf_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`IPF_ADDR_W-1:0] paddr,
  input  wire logic [`IPF_DATA_W-1:0] pwdata,
  input  wire logic [`IPF_STRB_W-1:0] pstrb,
  output logic      [`IPF_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Raw interrupt requests from the sources
  input  wire logic [`IPF_NSRC-1:0]   src_req,
  // Towards the arbiter
  output ipf_cfg_vec_t                src_cfg,
  output logic      [`IPF_NSRC-1:0]   svc_req,
  output logic                        top_level_req
);

  // ************************************************************
  // Field map
  // ************************************************************
  localparam logic [`IPF_ADDR_W-1:0] FLD_OFF [`IPF_NSRC] =
    '{`IPF_OFF_LOWV, `IPF_OFF_CHGT, `IPF_OFF_SER3, `IPF_OFF_SER3};
  localparam int FLD_LSB [`IPF_NSRC] =
    '{`IPF_LSB_LOWV, `IPF_LSB_CHGT, `IPF_LSB_S3RX, `IPF_LSB_S3TX};

  // Byte lane that carries a field starting at bit lsb
  function automatic logic lane_on(
    input logic [`IPF_STRB_W-1:0] strb,
    input int                     lsb
  );
    int lane;
    lane    = lsb / `IPF_LANE_W;
    lane_on = strb[lane];
  endfunction

  // Exact address compare over all twelve bits, low two bits included
  function automatic logic addr_hit(
    input logic [`IPF_ADDR_W-1:0] addr,
    input logic [`IPF_ADDR_W-1:0] off
  );
    addr_hit = (addr == off);
  endfunction

  // ************************************************************
  // Bus handshake
  // ************************************************************
  ipf_apb_st_t                st_q;
  ipf_apb_st_t                st_d;
  logic [`IPF_DATA_W-1:0]     prdata_q;
  logic [`IPF_DATA_W-1:0]     prdata_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;
  logic                       map_hit;
  logic                       wr_commit;
  logic [`IPF_DATA_W-1:0]     rd_word;

  logic [`IPF_PRIO_W-1:0]     fld_prio [`IPF_NSRC];
  logic [`IPF_NSRC-1:0]       fld_en;
  logic [`IPF_NSRC-1:0]       fld_we;

  assign map_hit = addr_hit(paddr, `IPF_OFF_LOWV) |
                   addr_hit(paddr, `IPF_OFF_CHGT) |
                   addr_hit(paddr, `IPF_OFF_SER3) |
                   addr_hit(paddr, `IPF_OFF_STAT);

  // Writes land only on the edge that completes the access
  assign wr_commit = psel & penable & pwrite & pready_q &
                     (st_q == IPF_ST_RESP) & map_hit;

  // Read data is registered on the same edge that raises pready so that every output
  // leaves a flip-flop; nothing else writes the fields in between.
  always_comb
  begin
    st_d      = st_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (srst)
    begin
      st_d     = IPF_ST_IDLE;
      prdata_d = '0;
    end
    else
    begin
      case (st_q)
        IPF_ST_IDLE:
        begin
          if (psel && !penable)
          begin
            st_d = IPF_ST_SETUP;
          end
          else if (psel && penable)
          begin
            st_d      = IPF_ST_RESP;
            pready_d  = 1'b1;
            pslverr_d = ~map_hit;
            prdata_d  = (map_hit && !pwrite) ? rd_word : '0;
          end
        end
        IPF_ST_SETUP:
        begin
          if (psel && penable)
          begin
            st_d      = IPF_ST_RESP;
            pready_d  = 1'b1;
            pslverr_d = ~map_hit;
            prdata_d  = (map_hit && !pwrite) ? rd_word : '0;
          end
          else if (!psel)
          begin
            st_d = IPF_ST_IDLE;
          end
        end
        IPF_ST_RESP:
        begin
          st_d = IPF_ST_IDLE;
        end
        default:
        begin
          st_d = IPF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st_q      <= st_d;
    prdata_q  <= prdata_d;
    pready_q  <= pready_d;
    pslverr_q <= pslverr_d;
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ************************************************************
  // Priority fields
  // ************************************************************
  // Only the field bits are stored, so the unused bits of each register
  // cannot hold anything a write puts there.
  generate
    for (genvar g = 0; g < `IPF_NSRC; g++)
    begin : g_fld
      assign fld_we[g] = wr_commit & addr_hit(paddr, FLD_OFF[g]) &
                         lane_on(pstrb, FLD_LSB[g]);           // [R3] [R5]

      ipf_field u_field
      (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .wr_en     (fld_we[g]),
        .wr_val    (pwdata[FLD_LSB[g] +: `IPF_PRIO_W]),        // [R1] [R4]
        .prio_q    (fld_prio[g]),
        .enabled_q (fld_en[g])
      );
    end
  endgenerate

  // ************************************************************
  // Read-back
  // ************************************************************
  logic [`IPF_DATA_W-1:0] stat_word;
  logic [`IPF_NSRC-1:0]   svc_req_q;
  logic [`IPF_NSRC-1:0]   svc_req_d;

  always_comb
  begin
    stat_word                  = '0;
    stat_word[`IPF_NSRC-1:0]   = svc_req_q;
    rd_word                    = '0;
    if (addr_hit(paddr, `IPF_OFF_LOWV))
    begin
      // Upper bits stay zero
      rd_word[`IPF_LSB_LOWV +: `IPF_PRIO_W] = fld_prio[`IPF_SRC_LOWV];
    end                                                        // [R1] [R3]
    else if (addr_hit(paddr, `IPF_OFF_CHGT))
    begin
      rd_word[`IPF_LSB_CHGT +: `IPF_PRIO_W] = fld_prio[`IPF_SRC_CHGT];
    end                                                        // [R4] [R5]
    else if (addr_hit(paddr, `IPF_OFF_SER3))
    begin
      rd_word[`IPF_LSB_S3RX +: `IPF_PRIO_W] = fld_prio[`IPF_SRC_S3RX];
      rd_word[`IPF_LSB_S3TX +: `IPF_PRIO_W] = fld_prio[`IPF_SRC_S3TX];
    end
    else if (addr_hit(paddr, `IPF_OFF_STAT))
    begin
      rd_word = stat_word;
    end
  end

  // ************************************************************
  // Request gating and configuration outputs
  // ************************************************************
  ipf_cfg_vec_t         src_cfg_q;
  ipf_cfg_vec_t         src_cfg_d;
  logic                 top_q;
  logic                 top_d;

  always_comb
  begin
    svc_req_d = '0;
    src_cfg_d = '0;
    top_d     = 1'b0;
    if (!srst)
    begin
      // A disabled source never reaches the arbiter
      svc_req_d = src_req & fld_en;                            // [R2]
      src_cfg_d.low_volt.prio       = fld_prio[`IPF_SRC_LOWV];
      src_cfg_d.low_volt.enabled    = fld_en[`IPF_SRC_LOWV];
      src_cfg_d.charge_time.prio    = fld_prio[`IPF_SRC_CHGT];
      src_cfg_d.charge_time.enabled = fld_en[`IPF_SRC_CHGT];
      src_cfg_d.serial3_rx.prio     = fld_prio[`IPF_SRC_S3RX];
      src_cfg_d.serial3_rx.enabled  = fld_en[`IPF_SRC_S3RX];
      src_cfg_d.serial3_tx.prio     = fld_prio[`IPF_SRC_S3TX];
      src_cfg_d.serial3_tx.enabled  = fld_en[`IPF_SRC_S3TX];
      for (int i = 0; i < `IPF_NSRC; i++)
      begin
        // Level seven is the ceiling; flag any live request there
        if (src_req[i] && fld_prio[i] == `IPF_PRIO_MAX)        // [R6]
        begin
          top_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    svc_req_q <= svc_req_d;
    src_cfg_q <= src_cfg_d;
    top_q     <= top_d;
  end

  assign svc_req       = svc_req_q;
  assign src_cfg       = src_cfg_q;
  assign top_level_req = top_q;

endmodule

// *** tb/ipf_prio_regs_properties.sv ***
/*
  Checker for the interrupt priority field bank: read-back layout, disable
  by zero, request gating, level-seven indicator and reset load.
  Assumes it is bound to ipf_prio_regs and sees only its ports.
*/
`timescale 1ns/1ps

`include "ipf_defines.svh"

module ipf_prio_checker
  import ipf_pkg::*;
(
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   srst,
  // APB
  input wire logic                   psel,
  input wire logic                   pwrite,
  input wire logic [`IPF_ADDR_W-1:0] paddr,
  input wire logic [`IPF_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Sources and arbiter side
  input wire logic [`IPF_NSRC-1:0]   src_req,
  input wire ipf_cfg_vec_t           src_cfg,
  input wire logic [`IPF_NSRC-1:0]   svc_req,
  input wire logic                   top_level_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_rd(logic [11:0] a);
    pready && psel && !pwrite && paddr == a;
  endsequence

  a_lowv_read: assert property (
    s_rd(12'h000) |-> prdata == {29'h0, src_cfg.low_volt.prio})
    else $error("low-voltage register read wrong");
  a_chgt_read: assert property (
    s_rd(12'h004) |-> prdata == {25'h0, src_cfg.charge_time.prio, 4'h0})
    else $error("charge-time register read wrong");
  a_zero_silent: assert property (
    (src_cfg.low_volt.prio == 3'h0) [*2] |-> !svc_req[0])
    else $error("disabled source still requests");
  a_enable_flag: assert property (
    src_cfg.charge_time.enabled == (src_cfg.charge_time.prio != 3'h0))
    else $error("enable flag disagrees with priority");
  a_svc_pass: assert property (
    src_req[1] ##1 src_cfg.charge_time.enabled |-> svc_req[1])
    else $error("enabled request not passed");
  a_top_level: assert property (
    !$past(srst) |-> top_level_req == |($past(src_req) & {
      src_cfg.serial3_tx.prio == 3'h7, src_cfg.serial3_rx.prio == 3'h7,
      src_cfg.charge_time.prio == 3'h7, src_cfg.low_volt.prio == 3'h7}))
    else $error("level seven indicator wrong");
  a_reset_load: assert property (
    $fell(srst) |=> src_cfg == 16'h9999)
    else $error("fields not at level four after reset");
  a_unmapped_err: assert property (
    pready && psel && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind ipf_prio_regs ipf_prio_checker ipf_prio_checker_i (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_req(src_req), .src_cfg(src_cfg), .svc_req(svc_req),
  .top_level_req(top_level_req));

// *** tb/tb.sv ***
/*
  Self-checking bench for the priority field bank: APB writes and reads,
  unmapped and strobe-less accesses, request gating by priority.
  Assumes the design's package and defines are compiled before it.
*/
`timescale 1ns/1ps

`include "ipf_defines.svh"

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end

module tb
  import ipf_pkg::*;
;
  logic                   sys_clk = 1'b0;
  logic                   srst    = 1'b1;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [`IPF_ADDR_W-1:0] paddr   = 12'h000;
  logic [`IPF_DATA_W-1:0] pwdata  = 32'h0;
  logic [`IPF_STRB_W-1:0] pstrb   = 4'hF;
  logic [`IPF_NSRC-1:0]   src_req = 4'h0;
  logic [`IPF_DATA_W-1:0] prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   top_level_req;
  logic [`IPF_NSRC-1:0]   svc_req;
  ipf_cfg_vec_t           src_cfg;
  int                     errors = 0;
  int                     samples_checked = 0;
  logic [31:0]            seed = 32'hD365;
  logic [31:0]            d;
  logic [31:0]            rd;
  logic                   er;
  logic [2:0]             lv_m = 3'h4;
  logic [2:0]             ct_m = 3'h4;
  logic [31:0]            corner [4] = '{32'hFFFFFFFF, 32'hFFFFFFFF,
                                         32'h0, 32'h0};

  always #5 sys_clk = ~sys_clk;

  ipf_prio_regs ipf_prio_regs_i (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .src_cfg(src_cfg), .svc_req(svc_req),
    .top_level_req(top_level_req));

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [11:0] a,
                                         input logic [2:0] p);
    return (a == 12'h004) ? {25'h0, p, 4'h0} : {29'h0, p};
  endfunction

  // ************************************************************
  // Bus master: called right after a rising edge
  // ************************************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic chk_regs();
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, exp_rd(12'h000, lv_m))
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, exp_rd(12'h004, ct_m))
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk_regs();
    $display("test reset values done");
    // Corners first: all unused bits set, then both fields zero
    for (int i = 0; i < 40; i++)
    begin
      d = (i < 4) ? corner[i] : nxt();
      src_req <= d[13:10];
      apb(1'b1, i[0] ? 12'h004 : 12'h000, d);
      if (i[0])
        ct_m = d[6:4];
      else
        lv_m = d[2:0];
      chk_regs();
    end
    $display("test random write read done");
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, ~{29'h0, lv_m});
    pstrb <= 4'hF;
    chk_regs();
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("test strobe and unmapped done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h70);
    src_req <= 4'h3;
    repeat (3) @(posedge sys_clk);
    `CHK(svc_req[1:0], 2'b10)
    `CHK(top_level_req, 1'b1)
    src_req <= 4'h1;
    repeat (3) @(posedge sys_clk);
    `CHK(top_level_req, 1'b0)
    src_req <= 4'h2;
    apb(1'b1, 12'h008, 32'hFFFF5300);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h00005300)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd, 32'h00000002)
    $display("test request gating done");
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule
